// >>> inc/sfsw_regs.svh
// Purpose: Constants for the serial flash status-write and read block
// Assumes: 125 MHz core clock; serial clock made by the host
// Notes: Function list below, one line per behaviour
//
// Function
// - Status write needs write latch set first
// - Status write data leaves latch and busy bits alone
// - Accept only exactly 8 or 16 data bits
// - Write cycle starts at chip select rise
// - Busy high during cycle; then clear latch
// - Lock bit with protect low rejects writes
// - Hardware lock when lock bit set and pin low, with quad and four-wire mode off
// - Hardware lock ends on pin high or four-wire mode
// - Four-wire mode or quad disables hardware lock
// - Otherwise software lock; lock bits writable
// - Protected region refuses program operations
// - Sample on rising, shift out on falling
// - Address increments per byte, wraps to zero
// - Read: opcode, three address bytes, data
// - Reads rejected while write cycle busy, except opcode-less reads in enhance mode
// - Fast and dual reads insert dummy clocks
// - Dual read: two bits per falling edge
// - Toggling mode bits keep enhance mode
// - Non-toggling mode bits leave enhance mode
// - Quad enable disables the lock pin
// - Region from top, or bottom when origin set
`ifndef SFSW_REGS_SVH
`define SFSW_REGS_SVH
// ============================================================
// Opcodes
`define SFSW_OP_STAT_WR 8'h01
`define SFSW_OP_LATCH_SET 8'h06
`define SFSW_OP_READ 8'h03
`define SFSW_OP_FAST 8'h0b
`define SFSW_OP_DUAL 8'h3b
// ============================================================
// Status and configuration layout
`define SFSW_SR_LOCK 7
`define SFSW_SR_QUAD 6
`define SFSW_SR_BUSY 0
`define SFSW_SR_LATCH 1
`define SFSW_CR_ORIGIN 3
`define SFSW_SR_RST 8'h00
`define SFSW_CR_RST 8'h07
// ============================================================
// Array geometry and timing
`define SFSW_ADDR_W 12
`define SFSW_BLK_W 4
`define SFSW_CLK_NS 8
`define SFSW_TW_NS 10000
`define SFSW_TW_CYC ((`SFSW_TW_NS + `SFSW_CLK_NS - 1) / `SFSW_CLK_NS)
`endif

// >>> inc/sfsw_pkg.sv
// Purpose: Types shared by the status-write and read block
// Assumes: Constants come from sfsw_regs.svh
// Notes: No imports; users write sfsw_pkg::name
package sfsw_pkg;
  // ============================================================
  // Link-side frame phases
  typedef enum logic [2:0] {PH_CMD, PH_ADDR, PH_DUMMY, PH_DATA, PH_WDATA, PH_IGN} sfsw_phase_e;
  // Frame report handed to the core domain
  typedef struct packed {
    logic tog;
    logic [7:0] op;
    logic [4:0] bits;
    logic [7:0] sr;
    logic [7:0] cr;
  } sfsw_frame_s;
  // Core state seen by the link
  typedef struct packed {
    logic busy;
    logic [1:0] dc;
  } sfsw_link_s;
endpackage : sfsw_pkg

// >>> hw/sfsw_top.sv
// Purpose: Status/config write, lock modes and array reads of a flash
// Assumes: Host stops the serial clock while chip select is high
// Notes: Small array; link logic on SCLK, registers on CORE_CLK
`timescale 1ns/1ns
`include "sfsw_regs.svh"
module sfsw_top (
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic SCLK,
  input wire logic CS_N,
  input wire logic IO_LINE_0_I,
  output logic IO_LINE_0_O,
  output logic IO_LINE_0_OE,
  output logic IO_LINE_1_O,
  output logic IO_LINE_1_OE,
  input wire logic WRITE_PROTECT_N,
  input wire logic FOUR_WIRE_MODE,
  input wire logic PROG_REQ,
  input wire logic [`SFSW_ADDR_W-1:0] PROG_ADDR,
  input wire logic [7:0] PROG_DATA,
  output logic PROG_ACK,
  output logic PROG_REJ,
  output logic [7:0] STATUS_REG,
  output logic [7:0] CONFIG_REG,
  output logic HW_LOCK_MODE
);
  // ============================================================
  // Declarations
  localparam int ABYTES = 1 << `SFSW_ADDR_W;
  logic [7:0] mem_q [0:ABYTES-1]; // Array contents
  logic [7:0] sr_q; // Status register
  logic [7:0] cr_q; // Configuration register
  logic [15:0] tw_q; // Write cycle countdown
  logic cs_m_q, cs_s_q, cs_d_q; // Chip select sync
  logic wp_m_q, wp_s_q; // Protect pin sync
  logic seen_q; // Last frame toggle handled
  logic hwl_q; // Hardware lock state
  logic ack_q, rej_q; // Program answers
  sfsw_pkg::sfsw_frame_s fr_q; // Frame report, link domain
  sfsw_pkg::sfsw_link_s lk_m_q, lk_s_q; // Core state into link
  sfsw_pkg::sfsw_phase_e ph_q; // Frame phase
  logic [4:0] bcnt_q; // Bit count in phase
  logic [23:0] sh_q; // Input shifter
  logic [7:0] op_q; // Current opcode
  logic [`SFSW_ADDR_W-1:0] addr_q; // Start address
  logic enh_q; // Performance enhance mode
  logic [2:0] obit_q; // Output bit index
  logic [`SFSW_ADDR_W-1:0] off_q; // Byte offset from start
  logic so1_q, oe1_q, so0_q, oe0_q; // Pin drivers
  logic frm_rst_n; // Frame reset, CS high
  logic cs_rise; // Frame end seen in core
  logic new_fr; // Frame not yet handled
  logic write_latch_set_cmd_ok, status_write_cmd_ok; // Accepted commands
  logic tw_done; // Write cycle finishing
  logic [7:0] opc; // Opcode on the eighth edge
  logic is_rd; // Opcode is a read
  logic [4:0] dum; // Dummy clocks needed
  logic [7:0] obyte; // Byte being shifted out
  logic prot_hit; // Program target protected
  logic [4:0] nblk; // Protected block count
  logic [`SFSW_BLK_W-1:0] pblk; // Target block

  // Frame logic is held reset whenever chip select is high
  assign frm_rst_n = RST_N & ~CS_N;

  // ============================================================
  // Core domain: pin synchronisers
  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      cs_m_q <= 1'b1;
      cs_s_q <= 1'b1;
      cs_d_q <= 1'b1;
      wp_m_q <= 1'b1;
      wp_s_q <= 1'b1;
    end
    else
    begin
      cs_m_q <= CS_N;
      cs_s_q <= cs_m_q;
      cs_d_q <= cs_s_q;
      wp_m_q <= WRITE_PROTECT_N;
      wp_s_q <= wp_m_q;
    end
  end

  // Frame report is stable once CS is high: SCLK has stopped
  assign cs_rise = cs_s_q & ~cs_d_q;
  assign new_fr = cs_rise & (fr_q.tog != seen_q);
  assign write_latch_set_cmd_ok = new_fr & (fr_q.op == `SFSW_OP_LATCH_SET) & (fr_q.bits == 5'h00)
    & ~sr_q[`SFSW_SR_BUSY];
  // Latch, bit count, busy and lock all gate the write
  assign status_write_cmd_ok = new_fr & (fr_q.op == `SFSW_OP_STAT_WR)
    & ((fr_q.bits == 5'h08) | (fr_q.bits == 5'h10))
    & sr_q[`SFSW_SR_LATCH]
    & ~sr_q[`SFSW_SR_BUSY] & ~hwl_q;
  assign tw_done = (tw_q == 16'h0001);

  // Remember which frame was handled, so a bare CS pulse is ignored
  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
      seen_q <= 1'b0;
    else if (cs_rise)
      seen_q <= fr_q.tog;
  end

  // ============================================================
  // Lock mode: either order of bit and pin enters it
  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
      hwl_q <= 1'b0;
    else
      // Pin high clears it; quad or four-wire mode disable it
      hwl_q <= sr_q[`SFSW_SR_LOCK] & ~wp_s_q
        & ~sr_q[`SFSW_SR_QUAD] & ~FOUR_WIRE_MODE;
  end

  // ============================================================
  // Status register: written bits, latch and busy
  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
      sr_q <= `SFSW_SR_RST;
    else
    begin
      // Data bits 1 and 0 are dropped; lock bits writable in soft mode
      if (status_write_cmd_ok)
        sr_q[7:2] <= fr_q.sr[7:2];
      // Latch set by the latch command, cleared at cycle end
      if (write_latch_set_cmd_ok)
        sr_q[`SFSW_SR_LATCH] <= 1'b1;
      else if (tw_done)
        sr_q[`SFSW_SR_LATCH] <= 1'b0;
      // Busy from CS rise until the countdown ends
      if (status_write_cmd_ok)
        sr_q[`SFSW_SR_BUSY] <= 1'b1;
      else if (tw_done)
        sr_q[`SFSW_SR_BUSY] <= 1'b0;
    end
  end

  // Configuration: only a 16-bit write touches it
  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
      cr_q <= `SFSW_CR_RST;
    else if (status_write_cmd_ok && fr_q.bits == 5'h10)
      // Origin bit is one-time: it can only be set
      cr_q <= {fr_q.cr[7:6], 2'b00, cr_q[`SFSW_CR_ORIGIN] | fr_q.cr[3], fr_q.cr[2:0]};
  end

  // Self-timed write cycle countdown
  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
      tw_q <= 16'h0000;
    else if (status_write_cmd_ok)
      tw_q <= 16'(`SFSW_TW_CYC);
    else if (tw_q != 16'h0000)
      tw_q <= tw_q - 16'h0001;
  end

  // ============================================================
  // Program port with region protection
  always_comb
  begin
    pblk = PROG_ADDR[`SFSW_ADDR_W-1 -: `SFSW_BLK_W];
    // Level n protects 2^(n-1) blocks, clamped to all of them
    if (sr_q[5:2] == 4'h0)
      nblk = 5'h00;
    else if (sr_q[5:2] > 4'h5)
      nblk = 5'h10;
    else
      nblk = 5'(5'h01 << (sr_q[5:2] - 4'h1));
    // Region grows from the top unless origin is set
    if (cr_q[`SFSW_CR_ORIGIN])
      prot_hit = ({1'b0, pblk} < nblk);
    else
      prot_hit = ({1'b0, pblk} >= (5'h10 - nblk));
  end

  // Array write; refused while busy or protected in either mode
  always_ff @(posedge CORE_CLK)
  begin
    if (PROG_REQ && !prot_hit && !sr_q[`SFSW_SR_BUSY])
      mem_q[PROG_ADDR] <= PROG_DATA;
  end

  // Program answers, one-cycle pulses
  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      ack_q <= 1'b0;
      rej_q <= 1'b0;
    end
    else
    begin
      ack_q <= PROG_REQ & ~prot_hit & ~sr_q[`SFSW_SR_BUSY];
      rej_q <= PROG_REQ & (prot_hit | sr_q[`SFSW_SR_BUSY]);
    end
  end

  // ============================================================
  // Link domain: core state brought over by two flops
  always_ff @(posedge SCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      lk_m_q <= '0;
      lk_s_q <= '0;
    end
    else
    begin
      // Eight opcode edges flush the pair before it is used
      lk_m_q <= {sr_q[`SFSW_SR_BUSY], cr_q[7:6]};
      lk_s_q <= lk_m_q;
    end
  end

  // Opcode decode and dummy length from the cycle bits
  always_comb
  begin
    opc = {sh_q[6:0], IO_LINE_0_I};
    is_rd = (opc == `SFSW_OP_READ) | (opc == `SFSW_OP_FAST) | (opc == `SFSW_OP_DUAL);
    unique case (lk_s_q.dc)
      2'b01: dum = 5'h06;
      2'b11: dum = 5'h0a;
      default: dum = 5'h08;
    endcase
  end

  // Frame sequencer, sampled on rising edges
  always_ff @(posedge SCLK or negedge frm_rst_n)
  begin
    if (!frm_rst_n)
    begin
      ph_q <= sfsw_pkg::PH_CMD;
      bcnt_q <= 5'h00;
      sh_q <= 24'h000000;
      op_q <= 8'h00;
      addr_q <= '0;
    end
    else
    begin
      sh_q <= {sh_q[22:0], IO_LINE_0_I};
      unique case (ph_q)
        sfsw_pkg::PH_CMD:
          // Enhance mode: first bit is already address
          if (bcnt_q == 5'h00 && enh_q)
          begin
            op_q <= `SFSW_OP_FAST;
            ph_q <= sfsw_pkg::PH_ADDR;
            bcnt_q <= 5'h01;
          end
          else if (bcnt_q == 5'h07)
          begin
            op_q <= opc;
            bcnt_q <= 5'h00;
            // Reads during a write cycle are dropped
            if (is_rd && !lk_s_q.busy)
              ph_q <= sfsw_pkg::PH_ADDR;
            else if (opc == `SFSW_OP_STAT_WR)
              ph_q <= sfsw_pkg::PH_WDATA;
            else
              ph_q <= sfsw_pkg::PH_IGN;
          end
          else
            bcnt_q <= bcnt_q + 5'h01;
        sfsw_pkg::PH_ADDR:
          if (bcnt_q == 5'h17)
          begin
            // Upper address bits fold onto the small array
            addr_q <= {sh_q[`SFSW_ADDR_W-2:0], IO_LINE_0_I};
            bcnt_q <= 5'h00;
            ph_q <= (op_q == `SFSW_OP_READ) ? sfsw_pkg::PH_DATA : sfsw_pkg::PH_DUMMY;
          end
          else
            bcnt_q <= bcnt_q + 5'h01;
        sfsw_pkg::PH_DUMMY:
          if (bcnt_q == dum - 5'h01)
          begin
            ph_q <= sfsw_pkg::PH_DATA;
            bcnt_q <= 5'h00;
          end
          else
            bcnt_q <= bcnt_q + 5'h01;
        default:
          ph_q <= ph_q;
      endcase
    end
  end

  // Frame report for the core, kept across CS high
  always_ff @(posedge SCLK or negedge RST_N)
  begin
    if (!RST_N)
      fr_q <= '0;
    else if (ph_q == sfsw_pkg::PH_CMD && bcnt_q == 5'h07)
    begin
      fr_q.tog <= ~fr_q.tog;
      fr_q.op <= opc;
      fr_q.bits <= 5'h00;
    end
    else if (ph_q == sfsw_pkg::PH_WDATA)
    begin
      // Count saturates so long frames never alias to 8 or 16
      if (fr_q.bits != 5'h1f)
        fr_q.bits <= fr_q.bits + 5'h01;
      if (fr_q.bits == 5'h07)
        fr_q.sr <= opc;
      if (fr_q.bits == 5'h0f)
        fr_q.cr <= opc;
    end
  end

  // Enhance mode, judged on the first dummy byte
  always_ff @(posedge SCLK or negedge RST_N)
  begin
    if (!RST_N)
      enh_q <= 1'b0;
    else if (ph_q == sfsw_pkg::PH_DUMMY && bcnt_q == 5'h07 && op_q == `SFSW_OP_FAST)
      // Nibbles complementary keep it; anything else ends it
      enh_q <= (opc[7:4] == ~opc[3:0]);
  end

  // ============================================================
  // Output shifter on falling edges
  assign obyte = mem_q[addr_q + off_q];

  always_ff @(negedge SCLK or negedge frm_rst_n)
  begin
    if (!frm_rst_n)
    begin
      obit_q <= 3'h0;
      off_q <= '0;
      so1_q <= 1'b0;
      oe1_q <= 1'b0;
      so0_q <= 1'b0;
      oe0_q <= 1'b0;
    end
    else if (ph_q == sfsw_pkg::PH_DATA)
    begin
      oe1_q <= 1'b1;
      if (op_q == `SFSW_OP_DUAL)
      begin
        // High bit on line 1, next bit on line 0
        so1_q <= obyte[3'h7 - obit_q];
        so0_q <= obyte[3'h6 - obit_q];
        oe0_q <= 1'b1;
        obit_q <= obit_q + 3'h2;
        if (obit_q == 3'h6)
          off_q <= off_q + 1'b1;
      end
      else
      begin
        so1_q <= obyte[3'h7 - obit_q];
        obit_q <= obit_q + 3'h1;
        if (obit_q == 3'h7)
          off_q <= off_q + 1'b1;
      end
    end
  end

  // ============================================================
  // Outputs
  assign IO_LINE_0_O = so0_q;
  assign IO_LINE_0_OE = oe0_q;
  assign IO_LINE_1_O = so1_q;
  assign IO_LINE_1_OE = oe1_q;
  assign PROG_ACK = ack_q;
  assign PROG_REJ = rej_q;
  assign STATUS_REG = sr_q;
  assign CONFIG_REG = cr_q;
  assign HW_LOCK_MODE = hwl_q;
endmodule : sfsw_top

// >>> tb/sfsw_host.sv
// Purpose: Host flash controller model that drives link frames
// Assumes: Mode 0 link; link clock idle low between frames
// Notes: Clock stands still while chip select is high
`timescale 1ns/1ns
module sfsw_host (
  output logic sclk,
  output logic cs_n,
  output logic si,
  input wire logic so1,
  input wire logic so0,
  input wire logic oe1
);
  logic oe_seen; // Data drive seen in last frame
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
    oe_seen = 1'b0;
  end
  // ======
  // One frame: n_out bits sent MSB first, then n_in read clocks
  task automatic xfer(input logic [39:0] out, input int n_out, input int n_in,
                      input bit dual, output logic [15:0] got);
    begin
      got = 16'h0000;
      oe_seen = 1'b0;
      #13 cs_n = 1'b0;
      for (int i = 0; i < n_out; i++)
      begin
        si = out[39 - i];
        #32 sclk = 1'b1;
        #32 sclk = 1'b0;
      end
      si = ~si; // Released line must not keep a stale level
      for (int i = 0; i < n_in; i++)
      begin
        #32 sclk = 1'b1;
        got = dual ? {got[13:0], so1, so0} : {got[14:0], so1};
        oe_seen = oe_seen | oe1;
        #32 sclk = 1'b0;
      end
      #16 cs_n = 1'b1; // Rises 16 ns after the last falling edge
    end
  endtask : xfer
endmodule : sfsw_host

// >>> tb/sfsw_top_sva.sv
// Purpose: Port checks of the status write and read block
// Assumes: Core clock view of the watched ports
// Notes: Bound into every top instance
`timescale 1ns/1ns
module sfsw_chk (
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic IO_LINE_0_OE,
  input wire logic IO_LINE_1_OE,
  input wire logic WRITE_PROTECT_N,
  input wire logic FOUR_WIRE_MODE,
  input wire logic PROG_REQ,
  input wire logic PROG_ACK,
  input wire logic PROG_REJ,
  input wire logic [7:0] STATUS_REG,
  input wire logic [7:0] CONFIG_REG,
  input wire logic HW_LOCK_MODE
);
  logic [10:0] busy_cnt_q; // Cycles spent busy so far
  default clocking
    @(posedge CORE_CLK);
  endclocking
  default disable iff (!RST_N);
  // ======
  // Busy length counter, cleared when idle
  always_ff @(posedge CORE_CLK or negedge RST_N)
    if (!RST_N)
      busy_cnt_q <= 11'h000;
    else if (STATUS_REG[0])
      busy_cnt_q <= busy_cnt_q + 11'h001;
    else
      busy_cnt_q <= 11'h000;
  // ======
  // Assertions
  chk_prog_answer: assert property (PROG_REQ |=> PROG_ACK != PROG_REJ)
    else $error("program request answered wrongly");
  chk_prog_busy: assert property (PROG_REQ && STATUS_REG[0] |=> PROG_REJ)
    else $error("program accepted while busy");
  chk_busy_len: assert property ($fell(STATUS_REG[0])
    |-> busy_cnt_q inside {[11'h4e1:11'h4e3]})
    else $error("write cycle length wrong");
  chk_done_latch: assert property ($fell(STATUS_REG[0]) |-> !STATUS_REG[1])
    else $error("latch not cleared at write end");
  chk_write_start: assert property ($changed({STATUS_REG[7:2], CONFIG_REG})
    |-> $rose(STATUS_REG[0]))
    else $error("registers changed without a write cycle");
  chk_busy_calm: assert property (STATUS_REG[0] && $past(STATUS_REG[0])
    |-> $stable({STATUS_REG[7:2], CONFIG_REG}))
    else $error("registers disturbed during write cycle");
  chk_lock_frozen: assert property (HW_LOCK_MODE |=> $stable(STATUS_REG[7:2]))
    else $error("locked bits changed in hardware lock");
  chk_lock_wire: assert property (FOUR_WIRE_MODE [*2] |-> !HW_LOCK_MODE)
    else $error("hardware lock in four-wire mode");
  chk_lock_quad: assert property (STATUS_REG[6] [*2] |-> !HW_LOCK_MODE)
    else $error("hardware lock with quad enabled");
  chk_lock_pin_hi: assert property (WRITE_PROTECT_N [*4] |-> !HW_LOCK_MODE)
    else $error("hardware lock kept with pin high");
  chk_lock_enter: assert property ((STATUS_REG[7] && !STATUS_REG[6] && !FOUR_WIRE_MODE
    && !WRITE_PROTECT_N) [*5] |-> HW_LOCK_MODE)
    else $error("hardware lock not entered");
  chk_dual_pair: assert property (IO_LINE_0_OE |-> IO_LINE_1_OE)
    else $error("line 0 driven outside dual data");
  chk_busy_quiet: assert property (STATUS_REG[0] [*8] |-> !IO_LINE_1_OE)
    else $error("read answered while busy");
endmodule : sfsw_chk
bind sfsw_top sfsw_chk u_chk (
  .CORE_CLK(CORE_CLK), .RST_N(RST_N), .IO_LINE_0_OE(IO_LINE_0_OE),
  .IO_LINE_1_OE(IO_LINE_1_OE), .WRITE_PROTECT_N(WRITE_PROTECT_N),
  .FOUR_WIRE_MODE(FOUR_WIRE_MODE), .PROG_REQ(PROG_REQ), .PROG_ACK(PROG_ACK),
  .PROG_REJ(PROG_REJ), .STATUS_REG(STATUS_REG), .CONFIG_REG(CONFIG_REG),
  .HW_LOCK_MODE(HW_LOCK_MODE)
);

// >>> tb/tb_sfsw_top.sv
// Purpose: Self-checking bench for the status write and read block
// Assumes: Host model frames on a 64 ns link clock
// Notes: Expected values come from a byte model of registers and array
`timescale 1ns/1ns
`include "sfsw_regs.svh"
module tb_sfsw_top;
  // ======
  // Clocks, pins and model state
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic sclk, cs_n, si, so0, oe0, so1, oe1, io0, io1;
  logic wp_n, four_w, prog_req, prog_ack, prog_rej, hw_lock;
  logic [`SFSW_ADDR_W-1:0] prog_addr;
  logic [7:0] prog_data, stat, conf, st, cf;
  logic [7:0] mem [int]; // Expected array bytes
  int errors = 0;
  int samples_checked = 0;
  int seed = 32'ha0a9;
  always #4 core_clk = ~core_clk;
  assign io0 = oe0 ? so0 : si; // Shared line 0 level
  assign io1 = oe1 ? so1 : sclk; // Undriven line keeps moving
  sfsw_top DUT (
    .CORE_CLK(core_clk), .RST_N(rst_n), .SCLK(sclk), .CS_N(cs_n),
    .IO_LINE_0_I(io0), .IO_LINE_0_O(so0), .IO_LINE_0_OE(oe0),
    .IO_LINE_1_O(so1), .IO_LINE_1_OE(oe1), .WRITE_PROTECT_N(wp_n),
    .FOUR_WIRE_MODE(four_w), .PROG_REQ(prog_req), .PROG_ADDR(prog_addr),
    .PROG_DATA(prog_data), .PROG_ACK(prog_ack), .PROG_REJ(prog_rej),
    .STATUS_REG(stat), .CONFIG_REG(conf), .HW_LOCK_MODE(hw_lock)
  );
  sfsw_host host (.sclk(sclk), .cs_n(cs_n), .si(si), .so1(io1), .so0(io0), .oe1(oe1));
  // ======
  // Helpers
  task automatic tally_and_finish;
    begin
      $display("Checks %0d, errors %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask : tally_and_finish
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    begin
      samples_checked++;
      if (got !== exp)
      begin
        errors++;
        $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
    end
  endtask : check
  task automatic wait_clk(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : wait_clk
  // Protected block test: 2^(n-1) of 16 blocks, top or bottom
  function automatic bit prot(input logic [11:0] a);
    int n;
    begin
      n = (st[5:2] > 5) ? 16 : ((st[5:2] == 0) ? 0 : (1 << (st[5:2] - 1)));
      prot = cf[3] ? (a[11:8] < n) : (a[11:8] >= 16 - n);
    end
  endfunction : prot
  task automatic regs;
    begin
      check("status", st, stat);
      check("config", cf, conf);
      check("hw lock", {7'h00, st[7] & ~st[6] & ~wp_n & ~four_w}, {7'h00, hw_lock});
    end
  endtask : regs
  task automatic prog(input logic [11:0] a);
    logic ok;
    logic [7:0] d;
    begin
      // Let one edge pass low, so back-to-back requests never merge
      wait_clk(1);
      d = 8'($random(seed));
      ok = !st[0] && !prot(a);
      prog_addr = a;
      prog_data = d;
      prog_req = 1'b1;
      wait_clk(1);
      prog_req = 1'b0;
      check("prog ack", {7'h00, ok}, {7'h00, prog_ack});
      check("prog rej", {7'h00, !ok}, {7'h00, prog_rej});
      if (ok)
        mem[a] = d;
    end
  endtask : prog
  // Mode byte fills the first dummy byte; skip sends no opcode (enhance mode)
  task automatic rd(input logic [7:0] op, input logic [11:0] a, input logic [7:0] m = 8'h00,
                    input bit skip = 1'b0);
    logic [15:0] g;
    logic [11:0] b;
    bit ok;
    begin
      b = a + 12'h001;
      ok = !st[0];
      host.xfer(skip ? {12'h000, a, m, 8'h00} : {op, 12'h000, a, m},
                (skip || op == `SFSW_OP_READ) ? 32 : 40,
                (op == `SFSW_OP_DUAL) ? 8 : 16, op == `SFSW_OP_DUAL, g);
      check("drive", {7'h00, ok}, {7'h00, host.oe_seen});
      if (ok)
      begin
        check("byte 0", mem[a], g[15:8]);
        check("byte 1", mem[b], g[7:0]);
      end
    end
  endtask : rd
  // Status write frame, optionally after a latch frame
  task automatic wstat(input logic [15:0] v, input int n, input bit latch);
    logic [15:0] g;
    bit acc;
    begin
      if (latch)
      begin
        host.xfer({8'h06, 32'h0}, 8, 0, 1'b0, g);
        st[1] = 1'b1;
      end
      acc = st[1] && (n == 8 || n == 16) && !(st[7] && !wp_n && !st[6] && !four_w);
      host.xfer({8'h01, v, 16'h0000}, 8 + n, 0, 1'b0, g);
      for (int k = 0; k < 12 && stat[0] !== 1'b1; k++)
        wait_clk(1);
      wait_clk(3);
      if (acc)
      begin
        st = {v[15:10], 2'b11};
        if (n == 16)
          cf = {v[7:6], 2'b00, cf[3] | v[3], v[2:0]};
      end
      regs();
      if (acc)
      begin
        rd(`SFSW_OP_FAST, 12'hfff);
        prog(12'h000);
        for (int k = 0; k < 1400 && stat[0] !== 1'b0; k++)
          wait_clk(1);
        st[1:0] = 2'b00;
      end
      regs();
    end
  endtask : wstat
  // ======
  // Main sequence
  initial
  begin
    wp_n = 1'b0;
    four_w = 1'b0;
    prog_req = 1'b0;
    prog_addr = 12'h000;
    prog_data = 8'h00;
    st = 8'h00;
    cf = 8'h07;
    wait_clk(4);
    rst_n = 1'b1;
    regs();
    prog(12'hfff);
    prog(12'h000);
    rd(`SFSW_OP_READ, 12'hfff);
    rd(`SFSW_OP_FAST, 12'hfff);
    rd(`SFSW_OP_DUAL, 12'hfff);
    // Toggling mode byte, then an opcode-less frame that ends the mode
    rd(`SFSW_OP_FAST, 12'hfff, 8'ha5);
    rd(`SFSW_OP_FAST, 12'hfff, 8'hff, 1'b1);
    rd(`SFSW_OP_READ, 12'hfff);
    wstat(16'h1c00, 8, 1'b0);
    wstat(16'h1c00, 9, 1'b1);
    wstat(16'h0700, 8, 1'b0);
    prog(12'hf00);
    prog(12'h0ff);
    wstat(16'h8408, 16, 1'b1);
    prog(12'h000);
    prog(12'hf00);
    wstat(16'h0000, 8, 1'b1);
    four_w = 1'b1;
    wait_clk(6);
    regs();
    four_w = 1'b0;
    wait_clk(6);
    regs();
    wp_n = 1'b1;
    wait_clk(6);
    regs();
    wstat(16'hc000, 8, 1'b1);
    wp_n = 1'b0;
    wait_clk(6);
    regs();
    tally_and_finish();
  end
  // Run needs about 60 us; allow over six times that
  initial
  begin
    #400000;
    errors++;
    tally_and_finish();
  end
endmodule : tb_sfsw_top
